// ### rtl/flash_seq_pkg.sv
// Constants and types for the flash command sequencer host
package flash_seq_pkg;
  // Register offsets on the AXI4-Lite port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_BASE = 8'h10;
  localparam logic [7:0] REG_POLL = 8'h14;
  localparam logic [7:0] REG_BUF = 8'h80;
  // Field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_HWRST_BIT = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_WIN_OPEN = 2;
  localparam int ST_WIN_EXPIRED = 3;
  localparam int ST_POLARITY = 4;
  localparam int ST_TOGGLE_MAIN = 5;
  localparam int ST_TOGGLE_SECTOR = 6;
  localparam int ST_ERASE_WIN_BIT = 7;
  localparam int DQ_POLARITY = 7;
  localparam int DQ_TOGGLE_MAIN = 6;
  localparam int DQ_ERASE_WIN = 3;
  localparam int DQ_TOGGLE_SECTOR = 2;
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [15:0] POLL_RST = 16'h0000;
  // Flash command words and unlock offsets
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_ARRAY_READ = 16'h00f0;
  localparam logic [11:0] OFS_UNLOCK1 = 12'h555;
  localparam logic [11:0] OFS_UNLOCK2 = 12'h2aa;
  // Write buffer geometry
  localparam int BUF_MAX_WORDS = 32;
  localparam int PAGE_WORDS = 32;
  localparam int PAGE_LSB = 5;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int PHASE_NS = 20;
  localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_ACCEPT_US = 50;
  localparam int ERASE_ACCEPT_CYC = ERASE_ACCEPT_US * CLK_MHZ;
  localparam int ADD_MARGIN_CYC = 4 * PHASE_CYC + 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2, OP_ADD_SECTOR = 3'h3, OP_ABORT_RESET = 3'h4, OP_POLL = 3'h5
  } op_t;
  typedef enum logic [1:0] {SEQ_IDLE = 2'h0, SEQ_ISSUE = 2'h1, SEQ_WAIT = 2'h2} seq_state_t;
  typedef enum logic [2:0] {
    CYC_IDLE = 3'h0, CYC_ADDR = 3'h1, CYC_LATCH = 3'h2, CYC_STROBE = 3'h3, CYC_RELEASE = 3'h4
  } cyc_state_t;
endpackage

// ### rtl/flash_bus_cycle.sv
// One flash bus cycle, write or read, on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle import flash_seq_pkg::*; #(
  parameter int FA_W = 24,
  parameter int DQ_W = 16,
  parameter int PHASE = PHASE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Cycle request
  input wire logic start,
  input wire logic is_read,
  input wire logic [FA_W-1:0] addr,
  input wire logic [DQ_W-1:0] wdata,
  output logic busy,
  output logic done,
  output logic data_latched,
  output logic [DQ_W-1:0] rdata,
  // Flash pins
  output logic flash_ce_n,
  output logic address_valid_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [FA_W-1:0] flash_addr,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DQ_W-1:0] dq_i
);
  cyc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic read_r, read_nxt;
  logic ce_n_r, ce_n_nxt, avd_n_r, avd_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt, dq_oe_r, dq_oe_nxt;
  logic latched_r, latched_nxt;
  logic [FA_W-1:0] addr_r, addr_nxt;
  logic [DQ_W-1:0] dq_o_r, dq_o_nxt, rdata_r, rdata_nxt, dq_s1_r, dq_s2_r;
  logic phase_end;

  assign phase_end = (cnt_r == 8'h00);
  assign busy = (state_r != CYC_IDLE);
  assign done = (state_r == CYC_RELEASE) && phase_end;
  assign data_latched = latched_r;
  assign rdata = rdata_r;
  assign flash_ce_n = ce_n_r;
  assign address_valid_n = avd_n_r;
  assign flash_we_n = we_n_r;
  assign flash_oe_n = oe_n_r;
  assign flash_addr = addr_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = phase_end ? 8'(PHASE - 1) : cnt_r - 8'h01;
    read_nxt = read_r;
    ce_n_nxt = ce_n_r;
    avd_n_nxt = avd_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    dq_oe_nxt = dq_oe_r;
    addr_nxt = addr_r;
    dq_o_nxt = dq_o_r;
    rdata_nxt = rdata_r;
    latched_nxt = 1'b0;
    case (state_r)
      CYC_IDLE: begin
        cnt_nxt = 8'(PHASE - 1);
        if (start) begin
          state_nxt = CYC_ADDR;
          read_nxt = is_read;
          ce_n_nxt = 1'b0;
          avd_n_nxt = 1'b0;
          addr_nxt = addr;
          dq_o_nxt = wdata;
        end
      end
      CYC_ADDR: if (phase_end) begin
        // Address is taken by the device on this rising edge
        state_nxt = CYC_LATCH;
        avd_n_nxt = 1'b1;
      end
      CYC_LATCH: if (phase_end) begin
        state_nxt = CYC_STROBE;
        oe_n_nxt = !read_r;
        we_n_nxt = read_r;
        dq_oe_nxt = !read_r;
      end
      CYC_STROBE: if (phase_end) begin
        // Write data is taken on the rising edge of the write strobe
        state_nxt = CYC_RELEASE;
        we_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        latched_nxt = !read_r;
        if (read_r) begin
          rdata_nxt = dq_s2_r;
        end
      end
      CYC_RELEASE: if (phase_end) begin
        state_nxt = CYC_IDLE;
        ce_n_nxt = 1'b1;
        dq_oe_nxt = 1'b0;
      end
      default: state_nxt = CYC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
    if (!rst_n) begin
      state_r <= CYC_IDLE;
      cnt_r <= 8'h00;
      read_r <= 1'b0;
      ce_n_r <= 1'b1;
      avd_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
      latched_r <= 1'b0;
      addr_r <= '0;
      dq_o_r <= '0;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      read_r <= read_nxt;
      ce_n_r <= ce_n_nxt;
      avd_n_r <= avd_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      dq_oe_r <= dq_oe_nxt;
      latched_r <= latched_nxt;
      addr_r <= addr_nxt;
      dq_o_r <= dq_o_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ### rtl/flash_seq_host.sv
// Host-side flash command sequencer with an AXI4-Lite register port
// Function
// R1 - Buffered program opens with AA at base+555 then 55 at base+2AA.
// R2 - Third write sends 0025 to the program address to start buffer load.
// R3 - Fourth write sends word count minus one at the program address.
// R4 - Buffered program carries one to thirty-two words, never more.
// R5 - All loaded word addresses stay inside one write buffer page.
// R6 - Pages align on multiples of 0x20; the start address picks the page.
// R7 - After the last word, 0029 is written at the sector address.
// R8 - Abort exit: unlock pair then 00F0 at base+555 returns to array read.
// R9 - Filling the buffer fully is advised for throughput, not required.
// R10 - Sector erase: unlock pair, 0080 at 555, unlock pair, 0030 at sector.
// R11 - Device preprograms to zeros itself before erasing; host does nothing.
// R12 - Erased sector words read back as FFFF.
// R13 - Device holds an acceptance window after erase for more sectors.
// R14 - Extra sector erase writes follow within the acceptance time.
// R15 - Any other command in the window returns the bank to array read.
// R16 - Device shows window expiry on a status bit the host can poll.
// R17 - The window starts at the write strobe rise of the last erase write.
// R18 - Erase completion returns the bank to array read, addresses released.
// R19 - Non-erasing banks still serve array reads during an erase.
// R20 - Reads of the erasing bank return poll and toggle status bits.
// R21 - During the internal erase only erase suspend is acted upon.
// R22 - Hardware reset aborts an erase; host repeats it after array read. The code never reissues the erase.
// R23 - Address taken on address-valid rise, data on write strobe rise.
// R24 - Anything but confirm after the declared loads aborts the program.
// R25 - A load count that differs from the declared count voids confirm.
// R26 - Loading a word outside the load sector aborts the program.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_host import flash_seq_pkg::*; #(
  parameter int FA_W = 24,
  parameter int DQ_W = 16,
  parameter int ERASE_ACCEPT = ERASE_ACCEPT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Flash pins
  output logic flash_reset_n,
  output logic flash_ce_n,
  output logic address_valid_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [FA_W-1:0] flash_addr,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DQ_W-1:0] dq_i
);
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, frst_n_r, frst_n_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, status_w;
  logic [FA_W-1:0] base_r, base_nxt, addr_r, addr_nxt;
  logic [5:0] count_r, count_nxt;
  logic [DQ_W-1:0] buf_r [BUF_MAX_WORDS], buf_nxt [BUF_MAX_WORDS];
  logic wr_fire, rd_fire, start_req, start_ok, hw_reset;
  op_t req_op;
  seq_state_t state_r, state_nxt;
  op_t op_r, op_nxt;
  logic [5:0] step_r, step_nxt;
  logic err_r, err_nxt, win_open_r, win_open_nxt;
  logic [31:0] win_cnt_r, win_cnt_nxt;
  logic [DQ_W-1:0] poll_r, poll_nxt;
  logic cyc_start, cyc_read, cyc_busy, cyc_done, cyc_latched, last_step;
  logic [FA_W-1:0] cyc_addr;
  logic [DQ_W-1:0] cyc_data, cyc_rdata;
  logic [6:0] page_end;
  logic [4:0] word_idx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Bus slave: address and data are taken together, one response at a time
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign flash_reset_n = frst_n_r;
  assign hw_reset = !frst_n_r;
  assign req_op = op_t'(s_axi_wdata[CTRL_OP_LSB +: 3]);
  assign start_req = wr_fire && (s_axi_awaddr == REG_CTRL) && s_axi_wstrb[0] && (req_op != OP_NONE);

  always_comb begin
    status_w = REG_RST;
    status_w[ST_BUSY] = (state_r != SEQ_IDLE) || cyc_busy;
    status_w[ST_ERR] = err_r;
    status_w[ST_WIN_OPEN] = win_open_r;
    status_w[ST_WIN_EXPIRED] = win_open_r && (win_cnt_r == 32'h0);
    status_w[ST_POLARITY] = poll_r[DQ_POLARITY];
    status_w[ST_TOGGLE_MAIN] = poll_r[DQ_TOGGLE_MAIN];
    status_w[ST_TOGGLE_SECTOR] = poll_r[DQ_TOGGLE_SECTOR];
    status_w[ST_ERASE_WIN_BIT] = poll_r[DQ_ERASE_WIN]; // R16
  end

  always_comb begin
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    base_nxt = base_r;
    addr_nxt = addr_r;
    count_nxt = count_r;
    buf_nxt = buf_r;
    frst_n_nxt = frst_n_r;
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (s_axi_awaddr == REG_CTRL) begin
        if (s_axi_wstrb[1]) begin
          frst_n_nxt = !s_axi_wdata[CTRL_HWRST_BIT]; // R22
        end
      end else if (s_axi_awaddr == REG_ADDR) begin
        addr_nxt = FA_W'(merge(32'(addr_r), s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr == REG_COUNT) begin
        count_nxt = 6'(merge(32'(count_r), s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr == REG_BASE) begin
        base_nxt = FA_W'(merge(32'(base_r), s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr >= REG_BUF) begin
        buf_nxt[s_axi_awaddr[6:2]] = DQ_W'(merge(32'(buf_r[s_axi_awaddr[6:2]]), s_axi_wdata, s_axi_wstrb));
      end else if (s_axi_awaddr != REG_STATUS && s_axi_awaddr != REG_POLL) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_nxt = {23'h0, hw_reset, 5'h0, op_r};
      end else if (s_axi_araddr == REG_ADDR) begin
        rdata_nxt = 32'(addr_r);
      end else if (s_axi_araddr == REG_COUNT) begin
        rdata_nxt = 32'(count_r);
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_nxt = status_w;
      end else if (s_axi_araddr == REG_BASE) begin
        rdata_nxt = 32'(base_r);
      end else if (s_axi_araddr == REG_POLL) begin
        rdata_nxt = 32'(poll_r);
      end else if (s_axi_araddr >= REG_BUF) begin
        rdata_nxt = 32'(buf_r[s_axi_araddr[6:2]]);
      end else begin
        rdata_nxt = REG_RST;
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= REG_RST;
      base_r <= FA_W'(REG_RST);
      addr_r <= FA_W'(REG_RST);
      count_r <= 6'(REG_RST);
      buf_r <= '{default: '0};
      frst_n_r <= 1'b1;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      base_r <= base_nxt;
      addr_r <= addr_nxt;
      count_r <= count_nxt;
      buf_r <= buf_nxt;
      frst_n_r <= frst_n_nxt;
    end
  end

  // Program checks: word count and single page from the start address
  assign page_end = 7'(addr_r[PAGE_LSB-1:0]) + 7'(count_r) - 7'h01; // R6
  assign word_idx = 5'(step_r - 6'h04);

  always_comb begin
    case (req_op)
      OP_PROGRAM: start_ok = (count_r != 6'h00) && (count_r <= 6'(BUF_MAX_WORDS))
                             && (page_end < 7'(PAGE_WORDS)); // R4 R5 R26
      OP_ADD_SECTOR: start_ok = win_open_r && (win_cnt_r > 32'(ADD_MARGIN_CYC)); // R14
      OP_ERASE, OP_ABORT_RESET, OP_POLL: start_ok = 1'b1;
      default: start_ok = 1'b0;
    endcase
    case (op_r)
      OP_PROGRAM: last_step = (step_r == count_r + 6'h04);
      OP_ERASE: last_step = (step_r == 6'h05);
      OP_ABORT_RESET: last_step = (step_r == 6'h02);
      default: last_step = 1'b1;
    endcase
  end

  // Address and data of the current step
  always_comb begin
    cyc_addr = base_r + FA_W'(OFS_UNLOCK1);
    cyc_data = CMD_UNLOCK1; // R1
    cyc_read = 1'b0;
    if ((op_r != OP_ADD_SECTOR) && (op_r != OP_POLL) && (step_r == 6'h01 || (op_r == OP_ERASE && step_r == 6'h04))) begin
      cyc_addr = base_r + FA_W'(OFS_UNLOCK2);
      cyc_data = CMD_UNLOCK2; // R1
    end else if (op_r == OP_PROGRAM && step_r == 6'h02) begin
      cyc_addr = addr_r;
      cyc_data = CMD_BUF_LOAD; // R2
    end else if (op_r == OP_PROGRAM && step_r == 6'h03) begin
      cyc_addr = addr_r;
      cyc_data = DQ_W'(count_r - 6'h01); // R3
    end else if (op_r == OP_PROGRAM && last_step) begin
      cyc_addr = addr_r + FA_W'(count_r - 6'h01);
      cyc_data = CMD_BUF_CONFIRM; // R7 R24 R25
    end else if (op_r == OP_PROGRAM && step_r >= 6'h04) begin
      cyc_addr = addr_r + FA_W'(word_idx); // R5
      cyc_data = buf_r[word_idx];
    end else if (op_r == OP_ERASE && step_r == 6'h02) begin
      cyc_data = CMD_ERASE_SETUP; // R10
    end else if ((op_r == OP_ERASE && step_r == 6'h05) || op_r == OP_ADD_SECTOR) begin
      cyc_addr = addr_r;
      cyc_data = CMD_SECTOR_ERASE; // R10 R13
    end else if (op_r == OP_ABORT_RESET && step_r == 6'h02) begin
      cyc_data = CMD_ARRAY_READ; // R8
    end else if (op_r == OP_POLL) begin
      cyc_addr = addr_r;
      cyc_read = 1'b1; // R20
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    step_nxt = step_r;
    err_nxt = err_r;
    win_open_nxt = win_open_r;
    win_cnt_nxt = (win_cnt_r != 32'h0) ? win_cnt_r - 32'h1 : win_cnt_r;
    poll_nxt = poll_r;
    cyc_start = 1'b0;
    case (state_r)
      SEQ_IDLE: if (start_req) begin
        if (start_ok && !cyc_busy && !hw_reset) begin
          state_nxt = SEQ_ISSUE;
          op_nxt = req_op;
          step_nxt = 6'h00;
          err_nxt = 1'b0;
          if (req_op != OP_POLL && req_op != OP_ADD_SECTOR) begin
            win_open_nxt = 1'b0; // R15
          end
        end else begin
          err_nxt = 1'b1;
        end
      end
      SEQ_ISSUE: begin
        cyc_start = 1'b1;
        state_nxt = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (cyc_latched && last_step && (op_r == OP_ERASE || op_r == OP_ADD_SECTOR)) begin
          win_open_nxt = 1'b1;
          win_cnt_nxt = 32'(ERASE_ACCEPT); // R17
        end
        if (cyc_done) begin
          if (op_r == OP_POLL) begin
            poll_nxt = cyc_rdata;
          end
          if (last_step) begin
            state_nxt = SEQ_IDLE;
          end else begin
            step_nxt = step_r + 6'h01;
            state_nxt = SEQ_ISSUE;
          end
        end
      end
      default: state_nxt = SEQ_IDLE;
    endcase
    if (start_req && state_r != SEQ_IDLE) begin
      err_nxt = 1'b1;
    end
    if (hw_reset) begin
      state_nxt = SEQ_IDLE; // R22
      win_open_nxt = 1'b0;
      win_cnt_nxt = 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= SEQ_IDLE;
      op_r <= OP_NONE;
      step_r <= 6'h00;
      err_r <= 1'b0;
      win_open_r <= 1'b0;
      win_cnt_r <= 32'h0;
      poll_r <= POLL_RST;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      err_r <= err_nxt;
      win_open_r <= win_open_nxt;
      win_cnt_r <= win_cnt_nxt;
      poll_r <= poll_nxt;
    end
  end

  flash_bus_cycle #(.FA_W(FA_W), .DQ_W(DQ_W), .PHASE(PHASE_CYC)) u_cycle (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .busy(cyc_busy),
    .done(cyc_done),
    .data_latched(cyc_latched),
    .rdata(cyc_rdata),
    .flash_ce_n(flash_ce_n),
    .address_valid_n(address_valid_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_addr(flash_addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_UNLOCK_FIRST: assert property (cyc_start && step_r == 6'h00 && (op_r == OP_PROGRAM || op_r == OP_ERASE ||
    op_r == OP_ABORT_RESET) |=> flash_addr == base_r + FA_W'(OFS_UNLOCK1) && dq_o == CMD_UNLOCK1) // R1
    else $error("first unlock write wrong");
  AST_UNLOCK_SECOND: assert property (cyc_start && step_r == 6'h01 && op_r != OP_POLL && op_r != OP_ADD_SECTOR
    |=> flash_addr == base_r + FA_W'(OFS_UNLOCK2) && dq_o == CMD_UNLOCK2) // R1
    else $error("second unlock write wrong");
  AST_LOAD_CMD: assert property (cyc_start && op_r == OP_PROGRAM && step_r == 6'h02 |=> dq_o == CMD_BUF_LOAD
    && flash_addr == addr_r) // R2
    else $error("buffer load command wrong");
  AST_WORD_COUNT: assert property (cyc_start && op_r == OP_PROGRAM && step_r == 6'h03 |=>
    dq_o == DQ_W'(count_r - 6'h01)) // R3
    else $error("word count write wrong");
  AST_COUNT_RANGE: assert property (state_r == SEQ_ISSUE && op_r == OP_PROGRAM |-> count_r >= 6'h01
    && count_r <= 6'h20) // R4
    else $error("program word count out of range");
  AST_SAME_PAGE: assert property (cyc_start && op_r == OP_PROGRAM && step_r >= 6'h04 |=>
    flash_addr[FA_W-1:PAGE_LSB] == addr_r[FA_W-1:PAGE_LSB]) // R5
    else $error("load left the write buffer page");
  AST_CONFIRM: assert property (cyc_start && op_r == OP_PROGRAM && last_step |-> step_r == count_r + 6'h04
    ##1 dq_o == CMD_BUF_CONFIRM) // R7
    else $error("confirm not after the declared loads");
  AST_ABORT_EXIT: assert property (cyc_start && op_r == OP_ABORT_RESET && step_r == 6'h02 |=>
    dq_o == CMD_ARRAY_READ && flash_addr == base_r + FA_W'(OFS_UNLOCK1)) // R8
    else $error("abort exit write wrong");
  AST_ERASE_SEQ: assert property (cyc_start && op_r == OP_ERASE && step_r == 6'h02 |=> dq_o == CMD_ERASE_SETUP
    ##[8:200] cyc_start && step_r == 6'h03) // R10
    else $error("erase setup sequence wrong");
  AST_ADD_SPACING: assert property (cyc_start && op_r == OP_ADD_SECTOR |-> win_open_r && win_cnt_r != 32'h0) // R14
    else $error("extra sector issued after the window");
  AST_HW_RESET: assert property (hw_reset |=> state_r == SEQ_IDLE && !win_open_r && (!flash_reset_n || $past(wr_fire))) // R22
    else $error("hardware reset did not stop the sequence");
endmodule
`default_nettype wire

// ### verif/flash_dev_model.sv
// Behavioural flash device: latches addresses, answers status reads
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // Host pins
  input wire logic address_valid_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] dq_o,
  // Data to host
  output logic [15:0] dq_i
);
  logic [23:0] cap_addr = '0;
  logic tog = 1'b0;
  logic erasing = 1'b0;
  initial dq_i = '0;
  always @(posedge address_valid_n) cap_addr <= flash_addr;
  always @(posedge flash_we_n) if (dq_o == 16'h0030) erasing = 1'b1;
  always @(negedge flash_reset_n) erasing = 1'b0;
  always @(negedge flash_oe_n) begin
    tog = ~tog;
    if (erasing)
      dq_i = {8'h00, 1'b0, tog, 2'b00, 1'b1, tog, 2'b00};
    else
      dq_i = 16'hffff;
  end
  always @(posedge flash_oe_n) dq_i = ~dq_i;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
`default_nettype none
module tb_top import flash_seq_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, x, seed = 32'h000109b1, w [2];
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [23:0] bs = 24'h001000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flash_reset_n, flash_ce_n;
  wire address_valid_n, flash_we_n, flash_oe_n, dq_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] flash_addr;
  wire [15:0] dq_o, dq_i;
  int fails = 0, checks_done = 0;
  logic [32:0] rq [$];
  logic [39:0] fq [$];
  flash_seq_host #(.ERASE_ACCEPT(200)) uut (
    .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .flash_reset_n, .flash_ce_n, .address_valid_n,
    .flash_we_n, .flash_oe_n, .flash_addr, .dq_o, .dq_oe, .dq_i
  );
  flash_dev_model m (.address_valid_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_addr, .dq_o, .dq_i);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic ex(input logic [23:0] a, input logic [15:0] d);
    fq.push_back({a, d});
  endtask
  task automatic unl();
    ex(bs + OFS_UNLOCK1, CMD_UNLOCK1);
    ex(bs + OFS_UNLOCK2, CMD_UNLOCK2);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic u);
    rq.push_back({u, e});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    x = s_axi_rdata;
  endtask
  task automatic idle();
    do axr(REG_STATUS, '0, 1'b0); while (x[ST_BUSY] !== 1'b0);
  endtask
  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1'b1 && rq.size() > 0 && rq[0][32])
      chk(s_axi_rdata, rq[0][31:0]);
    if (s_axi_rvalid === 1'b1)
      chk(s_axi_rresp, RESP_OKAY);
    if (s_axi_rvalid === 1'b1 && rq.size() > 0)
      void'(rq.pop_front());
  end
  always @(posedge flash_we_n) if (rst_n === 1'b1) begin
    chk({m.cap_addr, dq_o}, fq.pop_front());
    chk({flash_ce_n, dq_oe}, 2'b01);
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    axr(REG_BASE, '0, 1'b1);
    axw(8'h18, 32'h0, RESP_SLVERR);
    axw(REG_BASE, {8'h00, bs});
    axw(REG_ADDR, 32'h0020001e);
    axw(REG_COUNT, 32'h2);
    for (int i = 0; i < 2; i++) begin
      w[i] = rnd();
      axw(REG_BUF + 8'(4 * i), w[i]);
    end
    unl();
    ex(24'h20001e, CMD_BUF_LOAD);
    ex(24'h20001e, 16'h0001);
    ex(24'h20001e, w[0][15:0]);
    ex(24'h20001f, w[1][15:0]);
    ex(24'h20001f, CMD_BUF_CONFIRM);
    axw(REG_CTRL, 32'h1);
    idle();
    axw(REG_COUNT, 32'h3);
    axw(REG_CTRL, 32'h1);
    axr(REG_STATUS, 32'h2, 1'b1);
    unl();
    ex(bs + OFS_UNLOCK1, CMD_ARRAY_READ);
    axw(REG_CTRL, 32'h4);
    idle();
    axw(REG_ADDR, 32'h00040000);
    unl();
    ex(bs + OFS_UNLOCK1, CMD_ERASE_SETUP);
    unl();
    ex(24'h040000, CMD_SECTOR_ERASE);
    axw(REG_CTRL, 32'h2);
    idle();
    axw(REG_ADDR, 32'h00060000);
    ex(24'h060000, CMD_SECTOR_ERASE);
    axw(REG_CTRL, 32'h3);
    idle();
    axr(REG_STATUS, 32'h4, 1'b1);
    axw(REG_CTRL, 32'h5);
    idle();
    axr(REG_POLL, 32'h4c, 1'b1);
    repeat (250) @(posedge ref_clk);
    axr(REG_STATUS, '0, 1'b0);
    chk(x[ST_WIN_EXPIRED], 1'b1);
    axw(REG_CTRL, 32'h100);
    repeat (2) @(posedge ref_clk);
    chk(flash_reset_n, 1'b0);
    axr(REG_CTRL, 32'h105, 1'b1);
    axw(REG_CTRL, 32'h0);
    axw(REG_CTRL, 32'h5);
    idle();
    axr(REG_POLL, 32'hffff, 1'b1);
    chk(fq.size(), 0);
    complete_run();
  end
  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
